// *** sqcc_pkg.sv ***
// Behaviour
// [RULE1] - a set channel alarm mask stops that channel's alarms raising an interrupt
// [RULE2] - the channel alarm mask overrides the individual alarm mask bits
// [RULE3] - channel common control register resets to 0x40, alarm mask set
// [RULE4] - channel soft reinit resets its tx and rx logic, keeps configuration
// [RULE5] - soft reinit bits never clear themselves; software sets and clears
// [RULE6] - channel diag enable puts tx and rx in test; selection picks test
// [RULE7] - quad diag enable forces all channels to test, else channel bit decides
// [RULE8] - quad alarm suppress blocks all four channels' alarms from interrupting
// [RULE9] - quad soft reinit resets all four channels and overrides channel bits
// [RULE10] - quad tx power off powers down all transmitters, overriding channel bits
// [RULE11] - quad rx power off powers down all receivers, overriding channel bits
// [RULE12] - software writes zero to reserved bit zero of each channel register
// [RULE13] - quad global control resets to 0x44, suppress and reserved bit set
// [RULE14] - global control acts on its own quad; one instance per quad
// [RULE15] - 5-bit diag selection field follows global control, resets to zero
// [RULE16] - quad reinit, both power offs and quad diag enable reset to zero
// [RULE17] - printed bit zero is the most significant bit of each byte
// [RULE18] - alarm interrupts only when quad, channel and individual masks are clear
package sqcc_pkg;
  localparam int          IDX_W            = 18;
  localparam logic [17:0] CH_A_IDX         = 18'h30004;
  localparam logic [17:0] CH_B_IDX         = 18'h30014;
  localparam logic [17:0] CH_C_IDX         = 18'h30024;
  localparam logic [17:0] CH_D_IDX         = 18'h30034;
  localparam logic [17:0] GLB_IDX          = 18'h30005;
  localparam logic [17:0] DIAG_IDX         = 18'h30006;
  localparam logic [17:0] IRQ_STAT_IDX     = 18'h30040;
  localparam logic [17:0] IRQ_EN_IDX       = 18'h30041;
  // printed bit n sits at bit 7-n
  localparam int          CH_MASK_BIT      = 6;
  localparam int          CH_REINIT_BIT    = 5;
  localparam int          CH_DIAG_BIT      = 0;
  localparam int          GLB_SUPPRESS_BIT = 6;
  localparam int          GLB_REINIT_BIT   = 5;
  localparam int          GLB_TXOFF_BIT    = 4;
  localparam int          GLB_RXOFF_BIT    = 3;
  localparam int          GLB_DIAG_BIT     = 0;
  localparam int          DIAG_SEL_LSB     = 3;
  localparam int          DIAG_SEL_W       = 5;
  localparam logic [7:0]  CH_RST           = 8'h40;
  localparam logic [7:0]  CH_WMASK         = 8'h61;
  localparam logic [7:0]  GLB_RST          = 8'h44;
  localparam logic [7:0]  GLB_WMASK        = 8'h79;
  localparam logic [7:0]  GLB_FIXED        = 8'h04;
  localparam logic [7:0]  DIAG_RST         = 8'h00;
  localparam logic [7:0]  DIAG_WMASK       = 8'hf8;
  localparam logic [7:0]  IRQ_STAT_RST     = 8'h00;
  localparam logic [7:0]  IRQ_EN_RST       = 8'h00;
endpackage : sqcc_pkg

// *** sqcc_top.sv ***
// Local design decision: register access over APB.
module sqcc_top #(
  parameter logic [17:0] QUAD_OFFSET = 18'h00000
) (
  input  wire logic        I_SYS_CLK,              // 100 MHz system clock
  input  wire logic        I_RESETN,               // async reset, active low
  input  wire logic        I_PSEL,                 // apb select
  input  wire logic        I_PENABLE,              // apb access phase
  input  wire logic        I_PWRITE,               // apb write
  input  wire logic [19:0] I_PADDR,                // apb byte address
  input  wire logic [31:0] I_PWDATA,               // apb write data
  input  wire logic [3:0]  I_PSTRB,                // apb byte strobes
  output logic      [31:0] O_PRDATA,               // apb read data
  output logic             O_PREADY,               // apb ready
  output logic             O_PSLVERR,              // apb error, unmapped
  input  wire logic [3:0]  I_TX_ALARM,             // tx alarm per channel
  input  wire logic [3:0]  I_RX_ALARM,             // rx alarm per channel
  input  wire logic [3:0]  I_TX_ALARM_MASK,        // individual tx masks
  input  wire logic [3:0]  I_RX_ALARM_MASK,        // individual rx masks
  input  wire logic [3:0]  I_CHANNEL_TX_POWER_OFF, // per channel tx power off
  input  wire logic [3:0]  I_CHANNEL_RX_POWER_OFF, // per channel rx power off
  output logic      [3:0]  O_CH_SOFT_REINIT,       // tx/rx reset per channel
  output logic      [3:0]  O_CH_DIAG_MODE,         // test mode per channel
  output logic      [4:0]  O_DIAG_SELECTION,       // selected test
  output logic      [3:0]  O_TX_POWER_OFF,         // effective tx power off
  output logic      [3:0]  O_RX_POWER_OFF,         // effective rx power off
  output logic             O_IRQ                   // alarm interrupt level
);

  function automatic logic [17:0] ch_index(input int n);
    logic [17:0] r;
    r = sqcc_pkg::CH_A_IDX;
    case (n)
      1:       r = sqcc_pkg::CH_B_IDX;
      2:       r = sqcc_pkg::CH_C_IDX;
      3:       r = sqcc_pkg::CH_D_IDX;
      default: r = sqcc_pkg::CH_A_IDX;
    endcase
    return r;
  endfunction : ch_index

  logic [17:0] idx_w;
  logic        setup_w;
  logic        access_w;
  logic        wr_w;
  logic        rd_w;
  logic [3:0]  hit_ch;
  logic        hit_glb;
  logic        hit_diag;
  logic        hit_stat;
  logic        hit_en;
  logic        hit_any;
  logic [7:0]  rdata_w;

  logic [7:0]  ch_q [4];
  logic [7:0]  ch_d [4];
  logic [7:0]  glb_q;
  logic [7:0]  glb_d;
  logic [7:0]  diag_q;
  logic [7:0]  diag_d;
  logic [7:0]  stat_q;
  logic [7:0]  stat_d;
  logic [7:0]  en_q;
  logic [7:0]  en_d;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  logic [3:0]  ch_mask_w;
  logic [3:0]  ch_reinit_w;
  logic [3:0]  ch_diag_w;
  logic [7:0]  al_s1_q;
  logic [7:0]  al_s2_q;
  logic [7:0]  al_s3_q;
  logic [7:0]  al_lvl_q;
  logic [7:0]  al_lvl_d;
  logic [7:0]  rise_w;
  logic [7:0]  pass_w;
  logic [7:0]  clr_w;

  logic [3:0]  reinit_q;
  logic [3:0]  diag_mode_q;
  logic [4:0]  diag_sel_q;
  logic [3:0]  txoff_q;
  logic [3:0]  rxoff_q;
  logic        irq_q;

  // apb decode; the index is the byte address over four, less QUAD_OFFSET
  assign idx_w    = I_PADDR[19:2] - QUAD_OFFSET; // [RULE14]
  assign setup_w  = I_PSEL & ~I_PENABLE;
  assign access_w = I_PSEL & I_PENABLE & pready_q;
  assign wr_w     = access_w & I_PWRITE & I_PSTRB[0];
  assign rd_w     = access_w & ~I_PWRITE;
  assign hit_glb  = idx_w == sqcc_pkg::GLB_IDX;
  assign hit_diag = idx_w == sqcc_pkg::DIAG_IDX;
  assign hit_stat = idx_w == sqcc_pkg::IRQ_STAT_IDX;
  assign hit_en   = idx_w == sqcc_pkg::IRQ_EN_IDX;
  assign hit_any  = (|hit_ch) | hit_glb | hit_diag | hit_stat | hit_en;

  always_comb
  begin
    if (hit_ch[0])
      rdata_w = ch_q[0];
    else if (hit_ch[1])
      rdata_w = ch_q[1];
    else if (hit_ch[2])
      rdata_w = ch_q[2];
    else if (hit_ch[3])
      rdata_w = ch_q[3];
    else if (hit_glb)
      rdata_w = glb_q;
    else if (hit_diag)
      rdata_w = diag_q;
    else if (hit_stat)
      rdata_w = stat_q;
    else if (hit_en)
      rdata_w = en_q;
    else
      rdata_w = 8'h00;
  end

  // channel common control registers; reserved bits never stored
  genvar n;
  generate
    for (n = 0; n < 4; n++)
    begin : g_ch
      assign hit_ch[n]      = idx_w == ch_index(n);
      assign ch_d[n]        = (wr_w & hit_ch[n]) ?
                              (I_PWDATA[7:0] & sqcc_pkg::CH_WMASK) :
                              ch_q[n]; // [RULE17] [RULE5]
      assign ch_mask_w[n]   = ch_q[n][sqcc_pkg::CH_MASK_BIT];
      assign ch_reinit_w[n] = ch_q[n][sqcc_pkg::CH_REINIT_BIT];
      assign ch_diag_w[n]   = ch_q[n][sqcc_pkg::CH_DIAG_BIT];

      always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
          ch_q[n] <= sqcc_pkg::CH_RST; // [RULE3]
        else
          ch_q[n] <= ch_d[n];
      end
    end
  endgenerate

  assign glb_d  = (wr_w & hit_glb) ?
                  ((I_PWDATA[7:0] & sqcc_pkg::GLB_WMASK) |
                   sqcc_pkg::GLB_FIXED) : glb_q; // [RULE5]
  assign diag_d = (wr_w & hit_diag) ?
                  (I_PWDATA[7:0] & sqcc_pkg::DIAG_WMASK) : diag_q;
  assign en_d   = (wr_w & hit_en) ? I_PWDATA[7:0] : en_q;

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      glb_q  <= sqcc_pkg::GLB_RST; // [RULE13] [RULE16]
      diag_q <= sqcc_pkg::DIAG_RST; // [RULE15]
      en_q   <= sqcc_pkg::IRQ_EN_RST;
    end
    else
    begin
      glb_q  <= glb_d;
      diag_q <= diag_d;
      en_q   <= en_d;
    end
  end

  // answer in the first cycle of the access phase, one cycle after setup
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup_w;
      if (setup_w)
      begin
        prdata_q  <= {24'h00_0000, rdata_w};
        pslverr_q <= ~hit_any;
      end
    end
  end

  // alarms come from the serdes domain: three stages, agree on 2 and 3
  assign al_lvl_d = (al_s2_q & al_s3_q) | (al_lvl_q & (al_s2_q | al_s3_q));
  assign rise_w   = al_lvl_d & ~al_lvl_q;
  assign pass_w   = ~{I_RX_ALARM_MASK, I_TX_ALARM_MASK}
                  & ~{ch_mask_w, ch_mask_w}
                  & ~{8{glb_q[sqcc_pkg::GLB_SUPPRESS_BIT]}}; // [RULE1] [RULE2] [RULE8] [RULE18]
  // only bits actually returned by the read are cleared; a new set wins
  assign clr_w    = (rd_w & hit_stat) ? prdata_q[7:0] : 8'h00;
  assign stat_d   = (stat_q & ~clr_w) | (rise_w & pass_w);

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      al_s1_q  <= 8'h00;
      al_s2_q  <= 8'h00;
      al_s3_q  <= 8'h00;
      al_lvl_q <= 8'h00;
      stat_q   <= sqcc_pkg::IRQ_STAT_RST;
      irq_q    <= 1'b0;
    end
    else
    begin
      al_s1_q  <= {I_RX_ALARM, I_TX_ALARM};
      al_s2_q  <= al_s1_q;
      al_s3_q  <= al_s2_q;
      al_lvl_q <= al_lvl_d;
      stat_q   <= stat_d;
      irq_q    <= |(stat_d & en_d);
    end
  end

  // quad controls override the channel controls
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      reinit_q    <= 4'h0;
      diag_mode_q <= 4'h0;
      diag_sel_q  <= 5'h00;
      txoff_q     <= 4'h0;
      rxoff_q     <= 4'h0;
    end
    else
    begin
      reinit_q    <= {4{glb_q[sqcc_pkg::GLB_REINIT_BIT]}}
                   | ch_reinit_w; // [RULE4] [RULE9]
      diag_mode_q <= {4{glb_q[sqcc_pkg::GLB_DIAG_BIT]}}
                   | ch_diag_w; // [RULE6] [RULE7]
      diag_sel_q  <= diag_q[sqcc_pkg::DIAG_SEL_LSB +:
                            sqcc_pkg::DIAG_SEL_W]; // [RULE6] [RULE15]
      txoff_q     <= {4{glb_q[sqcc_pkg::GLB_TXOFF_BIT]}}
                   | I_CHANNEL_TX_POWER_OFF; // [RULE10]
      rxoff_q     <= {4{glb_q[sqcc_pkg::GLB_RXOFF_BIT]}}
                   | I_CHANNEL_RX_POWER_OFF; // [RULE11]
    end
  end

  assign O_PRDATA         = prdata_q;
  assign O_PREADY         = pready_q;
  assign O_PSLVERR        = pslverr_q;
  assign O_CH_SOFT_REINIT = reinit_q;
  assign O_CH_DIAG_MODE   = diag_mode_q;
  assign O_DIAG_SELECTION = diag_sel_q;
  assign O_TX_POWER_OFF   = txoff_q;
  assign O_RX_POWER_OFF   = rxoff_q;
  assign O_IRQ            = irq_q;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESETN);

  generate
    for (n = 0; n < 4; n++)
    begin : g_ast
      AST_CH_MASK_BLOCKS: assert property ( // [RULE1] [RULE2]
        ch_mask_w[n] |=> !(stat_q[n] && !$past(stat_q[n]))
                      && !(stat_q[n+4] && !$past(stat_q[n+4])))
        else $error("masked channel alarm set status");
      AST_CH_REINIT: assert property ( // [RULE4]
        ch_reinit_w[n] |=> O_CH_SOFT_REINIT[n])
        else $error("channel reinit not driven");
      AST_NO_SELF_CLEAR: assert property ( // [RULE5]
        ch_reinit_w[n] && !(wr_w && hit_ch[n]) |=> ch_reinit_w[n])
        else $error("channel reinit cleared itself");
    end
  endgenerate

  AST_CH_RESET_VAL: assert property ( // [RULE3]
    @(posedge I_SYS_CLK) $rose(I_RESETN) |->
      ch_q[0] == 8'h40 && ch_q[3] == 8'h40)
    else $error("channel register reset value wrong");
  AST_GLB_RESET_VAL: assert property ( // [RULE13]
    @(posedge I_SYS_CLK) $rose(I_RESETN) |-> glb_q == 8'h44)
    else $error("global register reset value wrong");
  AST_DIAG_RESET_VAL: assert property ( // [RULE15]
    @(posedge I_SYS_CLK) $rose(I_RESETN) |-> diag_q == 8'h00)
    else $error("diag select reset value wrong");
  AST_QUAD_SUPPRESS: assert property ( // [RULE8]
    glb_q[6] |=> (stat_q & ~$past(stat_q)) == 8'h00)
    else $error("status rose under quad suppress");
  AST_QUAD_REINIT: assert property ( // [RULE9]
    glb_q[5] |=> O_CH_SOFT_REINIT == 4'hf)
    else $error("quad reinit not on all channels");
  AST_DIAG_MODE: assert property ( // [RULE7]
    1'b1 |=> O_CH_DIAG_MODE == ({4{$past(glb_q[0])}} | $past(ch_diag_w)))
    else $error("diag mode wrong");
  AST_TX_OFF: assert property ( // [RULE10]
    glb_q[4] |=> O_TX_POWER_OFF == 4'hf)
    else $error("quad tx power off ignored");
  AST_RX_OFF: assert property ( // [RULE11]
    glb_q[3] |=> O_RX_POWER_OFF == 4'hf)
    else $error("quad rx power off ignored");
  AST_IRQ_PATH: assert property ( // [RULE18]
    (rise_w[0] && !I_TX_ALARM_MASK[0] && !ch_mask_w[0] && !glb_q[6]
     && en_q[0] && !(wr_w && hit_en)) |=> stat_q[0] ##0 O_IRQ)
    else $error("unmasked alarm did not interrupt");
  AST_APB_READY: assert property (
    setup_w |=> O_PREADY ##1 !O_PREADY)
    else $error("apb ready not one cycle after setup");

  // bus answers
  AST_READY_AFTER_SETUP: assert property (
    O_PREADY |-> $past(setup_w))
    else $error("apb ready without a setup cycle");

  AST_UNMAPPED_ERROR: assert property (
    setup_w && !hit_any |=> O_PSLVERR && O_PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused");

  AST_PRDATA_UPPER: assert property (
    O_PRDATA[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  // status and interrupt
  AST_READ_CLEARS: assert property ( // [RULE18]
    rd_w && hit_stat && (rise_w & pass_w) == 8'h00
      |=> (stat_q & $past(prdata_q[7:0])) == 8'h00)
    else $error("status bits survived their read");

  AST_STATUS_STICKY: assert property ( // [RULE18]
    !(rd_w && hit_stat) |=> ($past(stat_q) & ~stat_q) == 8'h00)
    else $error("status bit dropped without a read");

  AST_IRQ_LEVEL: assert property ( // [RULE18]
    O_IRQ == |(stat_q & en_q))
    else $error("irq level differs from enabled status");

  // global and diag select registers
  AST_GLB_FIXED_BIT: assert property ( // [RULE13]
    (glb_q & ~(sqcc_pkg::GLB_WMASK | sqcc_pkg::GLB_FIXED)) == 8'h00
      && glb_q[2])
    else $error("global reserved bits wrong");

  AST_QUAD_NO_SELF_CLEAR: assert property ( // [RULE5]
    glb_q[5] && !(wr_w && hit_glb) |=> glb_q[5])
    else $error("quad reinit cleared itself");

  AST_QUAD_DIAG_ALL: assert property ( // [RULE7]
    glb_q[0] |=> O_CH_DIAG_MODE == 4'hf)
    else $error("quad diag enable not on all channels");

  AST_DIAG_SEL: assert property ( // [RULE15]
    1'b1 |=> O_DIAG_SELECTION == $past(diag_q[7:3]))
    else $error("diag selection not taken from its register");

  AST_TX_OFF_CHANNEL: assert property ( // [RULE10]
    !glb_q[4] |=> O_TX_POWER_OFF == $past(I_CHANNEL_TX_POWER_OFF))
    else $error("channel tx power off not passed through");

  AST_RX_OFF_CHANNEL: assert property ( // [RULE11]
    !glb_q[3] |=> O_RX_POWER_OFF == $past(I_CHANNEL_RX_POWER_OFF))
    else $error("channel rx power off not passed through");

  // per channel storage and test mode
  generate
    for (n = 0; n < 4; n++)
    begin : g_ast_ch
      // reserved positions never hold a one
      AST_CH_RESERVED: assert property ( // [RULE17]
        (ch_q[n] & ~sqcc_pkg::CH_WMASK) == 8'h00)
        else $error("channel reserved bits stored");
      AST_CH_DIAG: assert property ( // [RULE6]
        ch_diag_w[n] |=> O_CH_DIAG_MODE[n])
        else $error("channel diag enable not driven");
    end
  endgenerate

endmodule : sqcc_top

// *** sqcc_top_test.sv ***
module sqcc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] GLB_A  = {sqcc_pkg::GLB_IDX, 2'b00};
  localparam logic [19:0] DIAG_A = {sqcc_pkg::DIAG_IDX, 2'b00};
  localparam logic [19:0] STAT_A = {sqcc_pkg::IRQ_STAT_IDX, 2'b00};
  localparam logic [19:0] EN_A   = {sqcc_pkg::IRQ_EN_IDX, 2'b00};
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [19:0] paddr   = '0;
  logic [31:0] pwdata  = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  tx_al   = '0;
  logic [3:0]  rx_al   = '0;
  logic [3:0]  tx_msk  = '0;
  logic [3:0]  rx_msk  = '0;
  logic [3:0]  pwr_tx  = '0;
  logic [3:0]  pwr_rx  = '0;
  logic [3:0]  reinit;
  logic [3:0]  diag;
  logic [4:0]  sel_o;
  logic [3:0]  tx_off;
  logic [3:0]  rx_off;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [15:0] seed    = 16'h0003;
  logic [7:0]  chv [4];
  logic [7:0]  glb;
  logic [7:0]  sel;
  logic [19:0] ch_a [4];
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles     = 0;

  sqcc_top #(.QUAD_OFFSET(18'h00000)) sqcc_top_i (
    .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_PSTRB(4'hf), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TX_ALARM(tx_al), .I_RX_ALARM(rx_al),
    .I_TX_ALARM_MASK(tx_msk), .I_RX_ALARM_MASK(rx_msk),
    .I_CHANNEL_TX_POWER_OFF(pwr_tx), .I_CHANNEL_RX_POWER_OFF(pwr_rx),
    .O_CH_SOFT_REINIT(reinit), .O_CH_DIAG_MODE(diag),
    .O_DIAG_SELECTION(sel_o), .O_TX_POWER_OFF(tx_off),
    .O_RX_POWER_OFF(rx_off), .O_IRQ(irq)
  );

  always #5 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // one bit of every channel register, channel A in bit 0
  function automatic logic [3:0] col(input int b);
    for (int c = 0; c < 4; c++)
      col[c] = chv[c][b];
  endfunction : col

  // a quad-wide bit overrides the per-channel bits
  function automatic logic [31:0] spread(input logic [3:0] b, input logic g);
    spread = {28'h0, b | {4{g}}};
  endfunction : spread

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [19:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic alarms(input logic [3:0] t, input logic [3:0] r);
    tx_al <= 4'h0;
    rx_al <= 4'h0;
    repeat (6) @(posedge clk);
    tx_al <= t;
    rx_al <= r;
    repeat (8) @(posedge clk);
  endtask : alarms

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  initial
  begin
    ch_a[0] = {sqcc_pkg::CH_A_IDX, 2'b00};
    ch_a[1] = {sqcc_pkg::CH_B_IDX, 2'b00};
    ch_a[2] = {sqcc_pkg::CH_C_IDX, 2'b00};
    ch_a[3] = {sqcc_pkg::CH_D_IDX, 2'b00};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b0, ch_a[c], 32'h0);
      chk("channel reset", 32'h40, rd);
    end
    apb(1'b0, GLB_A, 32'h0);
    chk("global reset", 32'h44, rd);
    apb(1'b0, DIAG_A, 32'h0);
    chk("diag reset", 32'h0, rd);
    chk("reset outputs", 32'h0, {reinit, diag, sel_o, tx_off, rx_off});
    apb(1'b0, 20'h00100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test reset done");
    for (int n = 0; n < 12; n++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        seed = lfsr(seed);
        chv[c] = seed[7:0] & 8'h61; // reserved bit written zero
        apb(1'b1, ch_a[c], {24'h0, chv[c]});
      end
      seed = lfsr(seed);
      glb = (n == 0) ? 8'h00 : (n == 1) ? 8'h79 : seed[7:0];
      apb(1'b1, GLB_A, {24'h0, glb});
      seed = lfsr(seed);
      sel = seed[7:0];
      apb(1'b1, DIAG_A, {24'h0, sel});
      pwr_tx <= seed[11:8];
      pwr_rx <= seed[15:12];
      repeat (4) @(posedge clk);
      for (int c = 0; c < 4; c++)
      begin
        apb(1'b0, ch_a[c], 32'h0);
        chk("channel readback", {24'h0, chv[c]}, rd);
      end
      apb(1'b0, GLB_A, 32'h0);
      chk("global readback", {24'h0, glb & 8'h79 | 8'h04}, rd);
      apb(1'b0, DIAG_A, 32'h0);
      chk("diag readback", {24'h0, sel & 8'hf8}, rd);
      chk("soft reinit", spread(col(5), glb[5]), {28'h0, reinit});
      chk("diag mode", spread(col(0), glb[0]), {28'h0, diag});
      chk("diag selection", {27'h0, sel[7:3]}, {27'h0, sel_o});
      chk("tx power off", spread(pwr_tx, glb[4]), {28'h0, tx_off});
      chk("rx power off", spread(pwr_rx, glb[3]), {28'h0, rx_off});
    end
    $display("test configuration done");
    apb(1'b1, GLB_A, 32'h0);
    for (int c = 0; c < 4; c++)
      apb(1'b1, ch_a[c], (c == 1) ? 32'h40 : 32'h0);
    apb(1'b1, EN_A, 32'hff);
    tx_msk <= 4'h4;
    alarms(4'hf, 4'h2);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, STAT_A, 32'h0);
    chk("alarm status", 32'h09, rd);
    repeat (2) @(posedge clk);
    chk("irq after read", 32'h0, {31'h0, irq});
    apb(1'b1, GLB_A, 32'h40);
    tx_msk <= 4'h0;
    alarms(4'hf, 4'hf);
    chk("irq suppressed", 32'h0, {31'h0, irq});
    apb(1'b0, STAT_A, 32'h0);
    chk("status suppressed", 32'h0, rd);
    apb(1'b1, GLB_A, 32'h0);
    apb(1'b1, EN_A, 32'h0);
    alarms(4'h1, 4'h0);
    chk("irq disabled", 32'h0, {31'h0, irq});
    apb(1'b1, EN_A, 32'h01);
    repeat (2) @(posedge clk);
    chk("irq enabled", 32'h1, {31'h0, irq});
    apb(1'b0, STAT_A, 32'h0);
    chk("status pending", 32'h01, rd);
    $display("test interrupt done");
    give_verdict();
  end
endmodule : sqcc_top_test
